// ==== src/mbr_map.vh ====
// constants of the modbus read responder: function codes, exception codes, address map
`ifndef MBR_MAP_VH
`define MBR_MAP_VH

// ==============================================================
// function codes and exception answers
`define MBR_FC_READ_COILS      8'h01
`define MBR_FC_READ_DISCRETES  8'h02
`define MBR_FC_READ_HOLDING    8'h03
`define MBR_FC_READ_INPUT_REGS 8'h04
`define MBR_EXC_FLAG           8'h80
`define MBR_EXC_BAD_FUNCTION   8'h01
`define MBR_EXC_BAD_ADDRESS    8'h02

// ==============================================================
// address windows and read-back offsets
`define MBR_LOW_MAX            17'h0_00FF
`define MBR_LOW_RB_MIN         17'h0_0200
`define MBR_LOW_RB_MAX         17'h0_02FF
`define MBR_LOW_RB_OFFSET      16'h0200
`define MBR_HIGH_MIN           17'h0_6000
`define MBR_HIGH_MAX           17'h0_62FC
`define MBR_HIGH_RB_MIN        17'h0_7000
`define MBR_HIGH_RB_MAX        17'h0_72FC
`define MBR_HIGH_RB_OFFSET     16'h1000

// ==============================================================
// frame layout and count limits
`define MBR_MAX_BITS           16'h0100
`define MBR_MAX_WORDS          16'h007D
`define MBR_MIN_FC_BYTES       4'h8
`define MBR_REQ_BYTES          4'hC
`define MBR_HDR_BYTES          9'h009
`define MBR_EXC_LENGTH         8'h03

`endif

// ==== src/mbr_read_responder.v ====
// modbus/tcp read-function responder: parses a request frame, reads the image, answers
//
// Behaviour
// - low addresses plus 0x0200 read back outputs
// - 6000-62FC hex plus 0x1000 read back outputs
// - code 0x01 reads input and output bits
// - bit value 1 is ON, 0 OFF
// - first bit in LSB of first byte
// - unused upper bits of last byte zero
// - code 0x01 failure answers 0x81 plus code
// - code 0x02 reads bits packed like coils
// - code 0x02 failure answers 0x82 plus code
// - code 0x03 returns holding registers as words
// - register references start at zero
// - two bytes per register, high first
// - code 0x04 returns input registers as words
// - code 0x03 failure answers 0x83 plus code
// - code 0x04 failure answers 0x84 plus code
// - frames travel over tcp port 502
// - incorrect request gets exception, not data; a frame of under 8 bytes gets no answer
// - 0x01 bad function, 0x02 bad address
`timescale 1ns/10ps
`include "mbr_map.vh"

module mbr_read_responder (
    input  wire        clk,
    input  wire        rst_b,
    input  wire [7:0]  rxData,
    input  wire        rxValid,
    input  wire        rxLast,
    output wire        rxReady,
    output reg  [7:0]  txData,
    output wire        txValid,
    output wire        txLast,
    input  wire        txReady,
    output reg  [15:0] imgAddr,
    output reg         imgRead,
    output reg         imgOutput,
    output reg         imgWord,
    input  wire [15:0] imgData
);

    // ==============================================================
    // states
    localparam [3:0] ST_IDLE   = 4'h1;
    localparam [3:0] ST_DECIDE = 4'h2;
    localparam [3:0] ST_GATHER = 4'h4;
    localparam [3:0] ST_SEND   = 4'h8;

    reg  [3:0]  state;
    reg  [3:0]  rxIdx;
    reg  [15:0] transId;
    reg  [7:0]  unitId;
    reg  [7:0]  funcCode;
    reg  [15:0] refAddr;
    reg  [15:0] itemCount;
    reg         isExc;
    reg  [7:0]  excCode;
    reg  [7:0]  byteCount;
    reg  [15:0] physBase;
    reg  [15:0] issueIdx;
    reg         pend;
    reg  [15:0] pendIdx;
    reg  [7:0]  bitAcc;
    reg  [8:0]  txIdx;
    reg  [7:0]  dataBuf [0:255];

    // ==============================================================
    // request decode
    reg         isBitFc;
    reg         isReadFc;
    reg  [16:0] endRef;
    reg         inLow;
    reg         inLowRb;
    reg         inHigh;
    reg         inHighRb;
    reg         countOk;
    reg  [15:0] next_physBase;
    reg  [8:0]  totalBytes;
    reg  [7:0]  next_txByte;
    reg  [7:0]  next_bitAcc;
    reg  [8:0]  byteSel;
    reg  [8:0]  bitBytes;

    // whole span must sit inside one window; a span that crosses windows is refused
    always @* begin
        isBitFc  = (funcCode == `MBR_FC_READ_COILS) || (funcCode == `MBR_FC_READ_DISCRETES);
        isReadFc = isBitFc || (funcCode == `MBR_FC_READ_HOLDING)
                   || (funcCode == `MBR_FC_READ_INPUT_REGS);
        endRef   = {1'b0, refAddr} + {1'b0, itemCount} - 17'h0_0001;
        inLow    = (endRef <= `MBR_LOW_MAX);
        inLowRb  = ({1'b0, refAddr} >= `MBR_LOW_RB_MIN) && (endRef <= `MBR_LOW_RB_MAX);
        inHigh   = ({1'b0, refAddr} >= `MBR_HIGH_MIN) && (endRef <= `MBR_HIGH_MAX);
        inHighRb = ({1'b0, refAddr} >= `MBR_HIGH_RB_MIN) && (endRef <= `MBR_HIGH_RB_MAX);
        countOk  = (itemCount != 16'h0000)
                   && (itemCount <= (isBitFc ? `MBR_MAX_BITS : `MBR_MAX_WORDS));
        bitBytes = itemCount[8:0] + 9'h007;             // rounded up, divided by 8 at use
        if (inLowRb) begin
            next_physBase = refAddr - `MBR_LOW_RB_OFFSET;
        end else if (inHighRb) begin
            next_physBase = refAddr - `MBR_HIGH_RB_OFFSET;
        end else begin
            next_physBase = refAddr;
        end
    end

    // ==============================================================
    // response byte selection
    always @* begin
        totalBytes = isExc ? `MBR_HDR_BYTES : (`MBR_HDR_BYTES + {1'b0, byteCount});
        byteSel    = (state == ST_SEND) ? (txIdx + 9'h001) : 9'h000;
        case (byteSel)
            9'h000:  next_txByte = transId[15:8];
            9'h001:  next_txByte = transId[7:0];
            9'h002:  next_txByte = 8'h00;
            9'h003:  next_txByte = 8'h00;
            9'h004:  next_txByte = 8'h00;
            9'h005:  next_txByte = isExc ? `MBR_EXC_LENGTH : (byteCount + `MBR_EXC_LENGTH);
            9'h006:  next_txByte = unitId;
            9'h007:  next_txByte = isExc ? (funcCode | `MBR_EXC_FLAG)
                                         : funcCode;
            9'h008:  next_txByte = isExc ? excCode : byteCount;
            default: next_txByte = dataBuf[byteSel[7:0] - 8'h09];
        endcase
    end

    // bit packing: item n lands at bit n%8, byte closes at 8 or at the last bit
    always @* begin
        next_bitAcc = bitAcc | ({7'h00, imgData[0]} << pendIdx[2:0]);
    end

    // ==============================================================
    // handshakes: only one frame in flight, receive stalls while answering
    assign rxReady = (state == ST_IDLE);
    assign txValid = (state == ST_SEND);
    assign txLast  = (state == ST_SEND) && (txIdx == totalBytes - 9'h001);

    // ==============================================================
    // main sequencer; tcp/port 502 handling lives upstream, frames arrive as bytes
    always @(posedge clk) begin
        if (!rst_b) begin
            state     <= ST_IDLE;
            rxIdx     <= 4'h0;
            transId   <= 16'h0000;
            unitId    <= 8'h00;
            funcCode  <= 8'h00;
            refAddr   <= 16'h0000;
            itemCount <= 16'h0000;
            isExc     <= 1'b0;
            excCode   <= 8'h00;
            byteCount <= 8'h00;
            physBase  <= 16'h0000;
            issueIdx  <= 16'h0000;
            pend      <= 1'b0;
            pendIdx   <= 16'h0000;
            bitAcc    <= 8'h00;
            txIdx     <= 9'h000;
            txData    <= 8'h00;
            imgAddr   <= 16'h0000;
            imgRead   <= 1'b0;
            imgOutput <= 1'b0;
            imgWord   <= 1'b0;
        end else begin
            imgRead <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (rxValid) begin
                        // bytes past the twelfth are ignored
                        case (rxIdx)
                            4'h0:    transId[15:8]   <= rxData;
                            4'h1:    transId[7:0]    <= rxData;
                            4'h6:    unitId          <= rxData;
                            4'h7:    funcCode        <= rxData;
                            4'h8:    refAddr[15:8]   <= rxData;
                            4'h9:    refAddr[7:0]    <= rxData;
                            4'hA:    itemCount[15:8] <= rxData;
                            4'hB:    itemCount[7:0]  <= rxData;
                            default: ;
                        endcase
                        if (rxIdx != `MBR_REQ_BYTES) begin
                            rxIdx <= rxIdx + 4'h1;
                        end
                        if (rxLast) begin
                            state <= ST_DECIDE;
                        end
                    end
                end
                ST_DECIDE: begin
                    rxIdx     <= 4'h0;
                    isExc     <= 1'b1;
                    txIdx     <= 9'h000;
                    txData    <= next_txByte;
                    physBase  <= next_physBase;
                    issueIdx  <= 16'h0000;
                    bitAcc    <= 8'h00;
                    byteCount <= isBitFc ? {2'b00, bitBytes[8:3]}
                                         : {itemCount[6:0], 1'b0};
                    if (rxIdx < `MBR_MIN_FC_BYTES) begin
                        state <= ST_IDLE;                 // too short to answer at all
                    end else if (!isReadFc) begin
                        excCode <= `MBR_EXC_BAD_FUNCTION;
                        state   <= ST_SEND;
                    end else if ((rxIdx < `MBR_REQ_BYTES) || !countOk
                                 || !(inLow || inLowRb || inHigh || inHighRb)) begin
                        excCode <= `MBR_EXC_BAD_ADDRESS;
                        state   <= ST_SEND;
                    end else begin
                        isExc     <= 1'b0;
                        imgOutput <= inLowRb || inHighRb;
                        imgWord   <= !isBitFc;
                        state     <= ST_GATHER;
                    end
                end
                ST_GATHER: begin
                    // image answers one cycle after each strobe
                    if (issueIdx != itemCount) begin
                        imgAddr  <= physBase + issueIdx;
                        imgRead  <= 1'b1;
                        issueIdx <= issueIdx + 16'h0001;
                    end
                    pend    <= imgRead;
                    pendIdx <= imgAddr - physBase;
                    if (pend && imgWord) begin
                        dataBuf[{pendIdx[6:0], 1'b0}] <= imgData[15:8];
                        dataBuf[{pendIdx[6:0], 1'b1}] <= imgData[7:0];
                    end else if (pend) begin
                        if ((pendIdx[2:0] == 3'h7) || (pendIdx == itemCount - 16'h0001)) begin
                            dataBuf[pendIdx[10:3]] <= next_bitAcc;
                            bitAcc <= 8'h00;
                        end else begin
                            bitAcc <= next_bitAcc;
                        end
                    end
                    if ((issueIdx == itemCount) && !imgRead && !pend) begin
                        state  <= ST_SEND;
                        txData <= next_txByte;
                    end
                end
                ST_SEND: begin
                    if (txReady) begin
                        if (txLast) begin
                            state <= ST_IDLE;
                        end else begin
                            txIdx  <= txIdx + 9'h001;
                            txData <= next_txByte;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // mbr_read_responder

// ==== sim/mbr_read_responder_monitor.sv ====
// checker on the read responder ports
`timescale 1ns/10ps
module mbr_read_responder_monitor (
    input wire        clk,
    input wire        rst_b,
    input wire [7:0]  rxData,
    input wire        rxValid,
    input wire        rxLast,
    input wire        rxReady,
    input wire [7:0]  txData,
    input wire        txValid,
    input wire        txLast,
    input wire        txReady,
    input wire [15:0] imgAddr,
    input wire        imgRead
);
    reg  [3:0]  rxCnt;
    reg  [8:0]  txCnt;
    reg  [15:0] tid;
    reg  [7:0]  fcode;
    wire        badFc = (fcode == 8'h00) || (fcode > 8'h04);
    // ==========================================================
    // frame trackers: byte index tells which field is on the wire
    always @(posedge clk) begin
        if (!rst_b) begin
            rxCnt <= 4'h0;
            txCnt <= 9'h000;
        end else begin
            if (rxValid && rxReady) begin
                rxCnt <= rxLast ? 4'h0 : rxCnt + {3'h0, rxCnt != 4'hF};
                if (rxCnt == 4'h0) tid[15:8] <= rxData;
                if (rxCnt == 4'h1) tid[7:0] <= rxData;
                if (rxCnt == 4'h7) fcode <= rxData;
            end
            if (txValid && txReady) txCnt <= txLast ? 9'h000 : txCnt + 9'h001;
        end
    end
    default clocking mbrCb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // header fields, hold and ordering
    chk_tid_echo: assert property (txValid && txCnt == 9'h000 |-> txData == tid[15:8])
        else $error("transaction id not echoed");
    chk_tid_low: assert property (txValid && txCnt == 9'h001 |-> txData == tid[7:0])
        else $error("transaction id low byte not echoed");
    chk_proto_zero: assert property (txValid && txCnt > 9'h001 && txCnt < 9'h005
        |-> txData == 8'h00)
        else $error("protocol id or length high not zero");
    chk_func_byte: assert property (txValid && txCnt == 9'h007
        |-> txData == (fcode | 8'h80) || (!badFc && txData == fcode))
        else $error("function byte wrong");
    chk_bad_func: assert property (txValid && txCnt == 9'h008 && badFc
        |-> txData == 8'h01)
        else $error("unsupported function not answered with code one");
    chk_exc_length: assert property (txValid && txCnt == 9'h005 && badFc
        |-> txData == 8'h03)
        else $error("exception length wrong");
    chk_tx_hold: assert property (txValid && !txReady
        |=> txValid && $stable(txData) && $stable(txLast))
        else $error("response byte dropped while stalled");
    // one frame at a time: intake must close as soon as a frame is complete
    chk_rx_closed: assert property (rxValid && rxReady && rxLast
        |=> !rxReady)
        else $error("request intake still open after last byte");
    chk_addr_step: assert property (imgRead && $past(imgRead)
        |-> imgAddr == $past(imgAddr) + 16'h0001)
        else $error("image reads not ascending");
endmodule // mbr_read_responder_monitor

bind mbr_read_responder mbr_read_responder_monitor mbr_read_responder_monitor_i (.clk(clk),
    .rst_b(rst_b), .rxData(rxData), .rxValid(rxValid), .rxLast(rxLast), .rxReady(rxReady),
    .txData(txData), .txValid(txValid), .txLast(txLast), .txReady(txReady),
    .imgAddr(imgAddr), .imgRead(imgRead));

// ==== sim/mbr_image_model.sv ====
// process image stand-in: answers one clock after each read strobe
`timescale 1ns/10ps
module mbr_image_model (
    input  wire        clk,
    input  wire [15:0] imgAddr,
    input  wire        imgRead,
    input  wire        imgOutput,
    input  wire        imgWord,
    output reg  [15:0] imgData
);
    initial imgData = 16'h0000;
    // between reads the bus flips, so a late sample never matches by luck
    always @(posedge clk) begin
        if (imgRead && imgWord)
            imgData <= imgAddr ^ 16'h3C5A ^ {16{imgOutput}};
        else if (imgRead)
            imgData <= {~imgData[15:1], ^imgAddr[3:0] ^ imgOutput};
        else
            imgData <= ~imgData;
    end
endmodule // mbr_image_model

// ==== sim/mbr_read_responder_test.sv ====
// self-checking bench for the modbus read responder
`timescale 1ns/10ps
module mbr_read_responder_test;
    typedef struct packed {logic [7:0] fc; logic [15:0] sref;
                           logic [15:0] cnt; logic [7:0] exc;} mbr_row_t;
    reg         clk;
    reg         rst_b;
    reg  [7:0]  rxData;
    reg         rxValid;
    reg         rxLast;
    reg         txReady;
    wire        rxReady;
    wire [7:0]  txData;
    wire        txValid;
    wire        txLast;
    wire [15:0] imgAddr;
    wire        imgRead;
    wire        imgOutput;
    wire        imgWord;
    wire [15:0] imgData;
    integer     failures;
    integer     checks;
    integer     k;
    integer     nGot;
    reg  [7:0]  gotB [0:299];
    reg  [7:0]  expB [0:299];
    mbr_row_t   rows [0:15];
    mbr_read_responder mbr_read_responder_i (.clk(clk), .rst_b(rst_b), .rxData(rxData),
        .rxValid(rxValid), .rxLast(rxLast), .rxReady(rxReady), .txData(txData),
        .txValid(txValid), .txLast(txLast), .txReady(txReady), .imgAddr(imgAddr),
        .imgRead(imgRead), .imgOutput(imgOutput), .imgWord(imgWord), .imgData(imgData));
    mbr_image_model mbr_image_model_i (.clk(clk), .imgAddr(imgAddr), .imgRead(imgRead),
        .imgOutput(imgOutput), .imgWord(imgWord), .imgData(imgData));
    // ==========================================================
    // helpers
    task cmp(input string name, input [15:0] e, input [15:0] g);
        checks = checks + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("[ERR] %0s expected %h seen %h", name, e, g);
        end
    endtask
    function [16:0] mapA(input [15:0] a);
        if (a >= 16'h0200 && a <= 16'h02FF) mapA = {1'b1, a - 16'h0200};
        else if (a >= 16'h7000 && a <= 16'h72FC) mapA = {1'b1, a - 16'h1000};
        else mapA = {1'b0, a};
    endfunction
    // one request in, whole answer out with the sink stalling every fourth cycle
    task runCase(input [7:0] fc, input [15:0] sref, input [15:0] cnt, input [7:0] exc,
                 input integer nb, input [15:0] tid);
        reg [7:0]  req [0:11];
        reg [16:0] m;
        reg [15:0] w;
        reg        fin;
        integer    i, n, bc, nExp;
        req = '{tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'h06, 8'h5A, fc,
                sref[15:8], sref[7:0], cnt[15:8], cnt[7:0]};
        bc = (exc != 8'h00) ? 0 : (fc > 8'h02) ? 2 * cnt : (cnt + 7) / 8;
        nExp = (nb < 8) ? 0 : 9 + bc;
        for (i = 0; i < 300; i = i + 1) expB[i] = 8'h00;
        expB[0] = tid[15:8];
        expB[1] = tid[7:0];
        expB[5] = 8'(bc + 3);
        expB[6] = 8'h5A;
        expB[7] = (exc != 8'h00) ? (fc | 8'h80) : fc;
        expB[8] = (exc != 8'h00) ? exc : 8'(bc);
        for (n = 0; n < cnt && exc == 8'h00; n = n + 1) begin
            m = mapA(sref + n[15:0]);
            w = m[15:0] ^ 16'h3C5A ^ {16{m[16]}};
            if (fc > 8'h02) {expB[9 + 2 * n], expB[10 + 2 * n]} = w;
            else expB[9 + n / 8][n % 8] = ^m[3:0] ^ m[16];
        end
        for (i = 0; i < nb; i = i + 1) begin
            while (rxReady !== 1'b1) @(posedge clk) #1;
            rxData = req[i];
            rxValid = 1'b1;
            rxLast = (i == nb - 1);
            @(posedge clk) #1;
        end
        rxValid = 1'b0;
        rxLast = 1'b0;
        nGot = 0;
        fin = 1'b0;
        for (i = 0; i < 3000 && !fin && nGot < 300; i = i + 1) begin
            txReady = (i % 4 != 3);
            if (txValid === 1'b1 && txReady) begin
                gotB[nGot] = txData;
                fin = (txLast === 1'b1);
                nGot = nGot + 1;
            end
            @(posedge clk) #1;
        end
        cmp("response length", 16'(nExp), 16'(nGot));
        for (i = 0; i < nGot && i < nExp; i = i + 1) begin
            cmp("response byte", 16'(expB[i]), 16'(gotB[i]));
        end
    endtask
    task give_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================================================
    // clock, watchdog, sequence
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #3_000_000;
        failures = failures + 1;
        give_verdict;
    end
    initial begin
        {rst_b, rxData, rxValid, rxLast, txReady} = 12'h000;
        failures = 0;
        checks = 0;
        rows = '{'{8'h01, 16'h0000, 16'h0008, 8'h00}, '{8'h02, 16'h0003, 16'h000B, 8'h00},
                 '{8'h03, 16'h0000, 16'h0002, 8'h00}, '{8'h04, 16'h6000, 16'h0003, 8'h00},
                 '{8'h01, 16'h0200, 16'h0009, 8'h00}, '{8'h03, 16'h7000, 16'h0002, 8'h00},
                 '{8'h04, 16'h62FC, 16'h0001, 8'h00}, '{8'h02, 16'h0000, 16'h0100, 8'h00},
                 '{8'h03, 16'h0000, 16'h007D, 8'h00}, '{8'h05, 16'h0000, 16'h0001, 8'h01},
                 '{8'h03, 16'h0000, 16'h0000, 8'h02}, '{8'h01, 16'h0000, 16'h0101, 8'h02},
                 '{8'h04, 16'h0000, 16'h007E, 8'h02}, '{8'h02, 16'h00FF, 16'h0002, 8'h02},
                 '{8'h03, 16'h62FC, 16'h0002, 8'h02}, '{8'h10, 16'h0000, 16'h0001, 8'h01}};
        repeat (4) @(posedge clk);
        #1 rst_b = 1'b1;
        for (k = 0; k < 16; k = k + 1)
            runCase(rows[k].fc, rows[k].sref, rows[k].cnt,
                    rows[k].exc, 12, 16'hA500 + k[15:0]);
        runCase(8'h03, 16'h0000, 16'h0001, 8'h02, 10, 16'h0BAD);
        // a frame too short to carry a function code gets no answer at all
        runCase(8'h03, 16'h0000, 16'h0001, 8'h02, 6, 16'h0C0D);
        // abort a frame halfway with reset; a stale byte count would skew the next answer
        rxData = 8'h77;
        rxValid = 1'b1;
        repeat (5) @(posedge clk) #1;
        rxValid = 1'b0;
        rst_b = 1'b0;
        @(posedge clk) #1;
        rst_b = 1'b1;
        cmp("ready after reset", 16'h0001, 16'(rxReady));
        runCase(8'h04, 16'h0201, 16'h0002, 8'h00, 12, 16'h1357);
        give_verdict;
    end
endmodule // mbr_read_responder_test
